/* core/ecc_pkg.sv */
package ecc_pkg;
    // prescaler for the internal counting clock
    localparam int unsigned PRESCALE_DIV  = 12;
    localparam logic [3:0]  PRESCALE_LAST = 4'(PRESCALE_DIV - 1);

    // register byte offsets
    localparam logic [7:0] ADDR_EVENT_MODE = 8'h00;
    localparam logic [7:0] ADDR_OUT_MODE   = 8'h04;
    localparam logic [7:0] ADDR_CMP_A      = 8'h08;
    localparam logic [7:0] ADDR_CMP_B      = 8'h0C;
    localparam logic [7:0] ADDR_COUNTER    = 8'h10;
    localparam logic [7:0] ADDR_CAPTURE    = 8'h14;
    localparam logic [7:0] ADDR_IRQ_STAT   = 8'h18;
    localparam logic [7:0] ADDR_IRQ_MASK   = 8'h1C;
    localparam logic [7:0] ADDR_PIN_STAT   = 8'h20;

    // event mode register field positions
    localparam int unsigned EM_CLK_LSB = 0;
    localparam int unsigned EM_CLR_LSB = 2;
    localparam int unsigned EM_OTA_LSB = 4;
    localparam int unsigned EM_OTB_LSB = 6;

    // output mode register bit positions
    localparam int unsigned OM_DRV_A = 0;
    localparam int unsigned OM_INV_A = 1;
    localparam int unsigned OM_RST_A = 2;
    localparam int unsigned OM_SET_A = 3;
    localparam int unsigned OM_DRV_B = 4;
    localparam int unsigned OM_INV_B = 5;
    localparam int unsigned OM_RST_B = 6;
    localparam int unsigned OM_SET_B = 7;
    localparam logic [7:0]  OM_SELF_CLR = 8'hDD;

    // interrupt status bit positions
    localparam int unsigned IRQ_A    = 0;
    localparam int unsigned IRQ_B    = 1;
    localparam int unsigned IRQ_EDGE = 2;

    // reset values
    localparam logic [7:0]  EVENT_MODE_RST = 8'h00;
    localparam logic [7:0]  OUT_MODE_RST   = 8'h00;
    localparam logic [15:0] CMP_RST        = 16'h0000;
    localparam logic [2:0]  IRQ_MASK_RST   = 3'h0;

    // bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_DECERR = 2'h3;

    typedef enum logic [1:0] {
        CLK_STOP  = 2'b00,
        CLK_GATED = 2'b01,
        CLK_FREE  = 2'b10,
        CLK_PIN   = 2'b11
    } ecc_clk_t;

    typedef enum logic [1:0] {
        CLR_NONE    = 2'b00,
        CLR_MATCH_B = 2'b01,
        CLR_EDGE    = 2'b10,
        CLR_HOLD    = 2'b11
    } ecc_clr_t;

    typedef enum logic [1:0] {
        TIM_NONE = 2'b00,
        TIM_A    = 2'b01,
        TIM_B    = 2'b10,
        TIM_AB   = 2'b11
    } ecc_tim_t;

    // field code to function tables, indexed by the two-bit field
    localparam ecc_clk_t CLK_TABLE [4] = '{CLK_STOP, CLK_GATED, CLK_FREE, CLK_PIN};
    localparam ecc_clr_t CLR_TABLE [4] = '{CLR_NONE, CLR_HOLD, CLR_EDGE, CLR_MATCH_B};
    localparam ecc_tim_t TIM_TABLE [4] = '{TIM_NONE, TIM_A, TIM_B, TIM_AB};
endpackage

/* core/ecc_out_chan.sv */
`timescale 1ns/1ps
module ecc_out_chan
    import ecc_pkg::*;
(
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // control
    input  wire logic timing_evt,
    input  wire logic invert_en,
    input  wire logic drive_now,
    input  wire logic level_set,
    input  wire logic level_reset,
    // state
    output logic      next_level,
    output logic      pin_out
);
    logic lv_q;
    logic pin_q;

    // first stage: software set/reset beats the flip at timing
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lv_q <= 1'b0;
        end else if (level_set) begin
            lv_q <= 1'b1; // see R14
        end else if (level_reset) begin
            lv_q <= 1'b0; // see R14
        end else if (timing_evt && invert_en) begin
            lv_q <= ~lv_q; // see R8
        end
    end

    // second stage: pin follows the level only at a timing event or a drive request
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_q <= 1'b0;
        end else if (timing_evt || drive_now) begin
            pin_q <= lv_q; // see R7
        end
    end

    assign next_level = lv_q;
    assign pin_out    = pin_q;
endmodule

/* core/ecc_top.sv */
`timescale 1ns/1ps
// Summary of operation
// R1: sixteen-bit upcounter, cleared by clear logic or a software write to its offset
// R2: capture on count-input or square-out falling edge
// R3: continuous equality compare against both registers
// R4: three events: match a, match b, edge
// R5: software writes 09H for pulse width
// R6: edge captures, clears counter, raises edge event
// R7: two-stage level flip-flop and output latch
// R8: timing copies level to pin, optionally flips
// R9: match b clears counter when selected
// R10: software prepares compare a below compare b
// R11: event mode fields: clock, clear, timings
// R12: internal count clock is divide by twelve
// R13: reset and stop zero both mode registers
// R14: output mode: drive, invert, level set/reset
// R15: drive and level bits clear themselves
// R16: square output selectable as reference source
// R17: two-bit fields decoded through lookup tables
module ecc_top
    import ecc_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // pins and neighbours
    input  wire logic        count_input_pin,
    input  wire logic        timer_square_out,
    input  wire logic        hw_stop,
    output logic             counter_output_a,
    output logic             counter_output_b,
    // interrupt
    output logic             irq
);
    // byte-lane merge of a write into an old word
    function automatic logic [31:0] strobed(input logic [31:0] old_w,
                                            input logic [31:0] new_w,
                                            input logic [3:0]  st);
        logic [31:0] r;
        r = old_w;
        for (int i = 0; i < 4; i++) begin
            if (st[i]) begin
                r[i*8 +: 8] = new_w[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // output timing field to event
    function automatic logic timing_hit(input logic [1:0] code,
                                        input logic       ev_a,
                                        input logic       ev_b);
        logic r;
        r = 1'b0;
        case (TIM_TABLE[code]) // see R17
            TIM_NONE: r = 1'b0;
            TIM_A:    r = ev_a;
            TIM_B:    r = ev_b;
            TIM_AB:   r = ev_a | ev_b;
            default:  r = 1'b0;
        endcase
        return r;
    endfunction

    logic [7:0]  event_mode_register_q;
    logic [7:0]  output_mode_register_q;
    logic [7:0]  output_mode_register_d;
    logic [15:0] compare_reg_a_q;
    logic [15:0] compare_reg_b_q;
    logic [15:0] event_upcounter_q;
    logic [15:0] capture_register_q;
    logic [2:0]  irq_stat_q;
    logic [2:0]  irq_mask_q;
    logic [3:0]  presc_q;
    logic        ci_s1_q;
    logic        ci_s2_q;
    logic        ci_prev_q;
    logic        to_prev_q;
    logic        match_a_q;
    logic        match_b_q;

    logic        aw_held_q;
    logic [7:0]  aw_addr_q;
    logic        w_held_q;
    logic [31:0] w_data_q;
    logic [3:0]  w_strb_q;
    logic        bvalid_q;
    logic [1:0]  bresp_q;
    logic        rvalid_q;
    logic [31:0] rdata_q;
    logic [1:0]  rresp_q;

    logic        do_write;
    logic        wr_known;
    logic [31:0] rd_word;
    logic        rd_known;
    logic        phi12;
    logic        ci_fall;
    logic        to_fall;
    logic        tick;
    logic        cap_evt;
    logic        clr_evt;
    logic        match_a;
    logic        match_b;
    logic        ev_a;
    logic        ev_b;
    logic        tim_a;
    logic        tim_b;
    logic        lvl_a;
    logic        lvl_b;
    logic        out_a;
    logic        out_b;
    logic [2:0]  irq_set;
    logic [31:0] wr_merged;
    ecc_clk_t    clk_sel;
    ecc_clr_t    clr_sel;

    // field decode
    assign clk_sel = CLK_TABLE[event_mode_register_q[EM_CLK_LSB +: 2]]; // see R11
    assign clr_sel = CLR_TABLE[event_mode_register_q[EM_CLR_LSB +: 2]]; // see R17

    // write channel: address and data held independently
    assign s_axi_awready = ~aw_held_q;
    assign s_axi_wready  = ~w_held_q;
    assign do_write      = aw_held_q & w_held_q & ~bvalid_q;
    assign wr_merged     = strobed(32'h0000_0000, w_data_q, w_strb_q);

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_held_q  <= 1'b0;
            w_data_q  <= 32'h0000_0000;
            w_strb_q  <= 4'h0;
        end else begin
            if (s_axi_awvalid && !aw_held_q) begin
                aw_held_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
            end else if (do_write) begin
                aw_held_q <= 1'b0;
            end
            if (s_axi_wvalid && !w_held_q) begin
                w_held_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
            end else if (do_write) begin
                w_held_q <= 1'b0;
            end
        end
    end

    // write decode validity
    always_comb begin
        case (aw_addr_q)
            ADDR_EVENT_MODE, ADDR_OUT_MODE, ADDR_CMP_A, ADDR_CMP_B,
            ADDR_COUNTER, ADDR_CAPTURE, ADDR_IRQ_STAT, ADDR_IRQ_MASK,
            ADDR_PIN_STAT: wr_known = 1'b1;
            default:       wr_known = 1'b0;
        endcase
    end

    // write response, decode error on unmapped offsets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_q <= 1'b0;
            bresp_q  <= RESP_OKAY;
        end else if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q  <= wr_known ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
        end
    end

    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp  = bresp_q;

    // event mode register; stop forces it clear
    always_ff @(posedge aclk) begin
        if (!aresetn || hw_stop) begin
            event_mode_register_q <= EVENT_MODE_RST; // see R13
        end else if (do_write && aw_addr_q == ADDR_EVENT_MODE && w_strb_q[0]) begin
            event_mode_register_q <= w_data_q[7:0]; // see R5
        end
    end

    // one-shot bits live for a single cycle, which is when they act
    always_comb begin
        output_mode_register_d = output_mode_register_q & ~OM_SELF_CLR; // see R15
        if (do_write && aw_addr_q == ADDR_OUT_MODE && w_strb_q[0]) begin
            output_mode_register_d = w_data_q[7:0];
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn || hw_stop) begin
            output_mode_register_q <= OUT_MODE_RST; // see R13
        end else begin
            output_mode_register_q <= output_mode_register_d;
        end
    end

    // compare registers, byte enables honoured
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            compare_reg_a_q <= CMP_RST;
            compare_reg_b_q <= CMP_RST;
        end else if (do_write) begin
            if (aw_addr_q == ADDR_CMP_A) begin
                compare_reg_a_q <= 16'(strobed({16'h0000, compare_reg_a_q}, w_data_q,
                                               w_strb_q));
            end
            if (aw_addr_q == ADDR_CMP_B) begin
                compare_reg_b_q <= 16'(strobed({16'h0000, compare_reg_b_q}, w_data_q,
                                               w_strb_q));
            end
        end
    end

    // count input crosses in; square output is same-clock logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ci_s1_q   <= 1'b0;
            ci_s2_q   <= 1'b0;
            ci_prev_q <= 1'b0;
            to_prev_q <= 1'b0;
        end else begin
            ci_s1_q   <= count_input_pin;
            ci_s2_q   <= ci_s1_q;
            ci_prev_q <= ci_s2_q;
            to_prev_q <= timer_square_out;
        end
    end

    assign ci_fall = ci_prev_q & ~ci_s2_q;
    assign to_fall = to_prev_q & ~timer_square_out;

    // divide-by-twelve internal count clock as a one-cycle enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            presc_q <= 4'h0;
        end else if (presc_q == PRESCALE_LAST) begin
            presc_q <= 4'h0; // see R12
        end else begin
            presc_q <= presc_q + 4'h1;
        end
    end

    assign phi12 = (presc_q == PRESCALE_LAST);

    // counter input select
    always_comb begin
        case (clk_sel)
            CLK_STOP:  tick = 1'b0;
            CLK_GATED: tick = phi12 & ci_s2_q; // see R5
            CLK_FREE:  tick = phi12;
            CLK_PIN:   tick = ci_fall;
            default:   tick = 1'b0;
        endcase
    end

    // capture edge: square output stands in when the pin is counted
    assign cap_evt = (clk_sel == CLK_PIN) ? to_fall : ci_fall; // see R2, R16

    // compare against both registers
    assign match_a = (event_upcounter_q == compare_reg_a_q); // see R3
    assign match_b = (event_upcounter_q == compare_reg_b_q); // see R3

    // match lasts while the count holds; events fire on its start only
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            match_a_q <= 1'b0;
            match_b_q <= 1'b0;
        end else begin
            match_a_q <= match_a;
            match_b_q <= match_b;
        end
    end

    assign ev_a = match_a & ~match_a_q;
    assign ev_b = match_b & ~match_b_q;

    // clear select
    always_comb begin
        case (clr_sel)
            CLR_NONE:    clr_evt = 1'b0;
            CLR_MATCH_B: clr_evt = match_b; // see R9
            CLR_EDGE:    clr_evt = cap_evt; // see R6
            CLR_HOLD:    clr_evt = 1'b1;
            default:     clr_evt = 1'b0;
        endcase
    end

    // upcounter; a software write to its offset also clears it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            event_upcounter_q <= 16'h0000;
        end else if (clr_evt || (do_write && aw_addr_q == ADDR_COUNTER)) begin
            event_upcounter_q <= 16'h0000; // see R1
        end else if (tick) begin
            event_upcounter_q <= event_upcounter_q + 16'h0001; // see R1
        end
    end

    // capture takes the count before any same-cycle clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            capture_register_q <= 16'h0000;
        end else if (cap_evt) begin
            capture_register_q <= event_upcounter_q; // see R6
        end
    end

    // output channels
    assign tim_a = timing_hit(event_mode_register_q[EM_OTA_LSB +: 2], ev_a, ev_b);
    assign tim_b = timing_hit(event_mode_register_q[EM_OTB_LSB +: 2], ev_a, ev_b);

    ecc_out_chan u_chan_a (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .timing_evt  (tim_a), // see R8
        .invert_en   (output_mode_register_q[OM_INV_A]),
        .drive_now   (output_mode_register_q[OM_DRV_A]),
        .level_set   (output_mode_register_q[OM_SET_A]),
        .level_reset (output_mode_register_q[OM_RST_A]),
        .next_level  (lvl_a),
        .pin_out     (out_a)
    );

    ecc_out_chan u_chan_b (
        .aclk        (aclk),
        .aresetn     (aresetn),
        .timing_evt  (tim_b), // see R8
        .invert_en   (output_mode_register_q[OM_INV_B]),
        .drive_now   (output_mode_register_q[OM_DRV_B]),
        .level_set   (output_mode_register_q[OM_SET_B]),
        .level_reset (output_mode_register_q[OM_RST_B]),
        .next_level  (lvl_b),
        .pin_out     (out_b)
    );

    assign counter_output_a = out_a;
    assign counter_output_b = out_b;

    // sticky status: a new event wins over a same-cycle clear
    assign irq_set = {cap_evt, ev_b, ev_a}; // see R4

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_stat_q <= 3'h0;
        end else if (do_write && aw_addr_q == ADDR_IRQ_STAT) begin
            irq_stat_q <= (irq_stat_q & ~wr_merged[2:0]) | irq_set;
        end else begin
            irq_stat_q <= irq_stat_q | irq_set;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            irq_mask_q <= IRQ_MASK_RST;
        end else if (do_write && aw_addr_q == ADDR_IRQ_MASK && w_strb_q[0]) begin
            irq_mask_q <= w_data_q[2:0];
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // read decode
    always_comb begin
        rd_word  = 32'h0000_0000;
        rd_known = 1'b1;
        case (s_axi_araddr)
            ADDR_EVENT_MODE: rd_word[7:0]  = event_mode_register_q;
            ADDR_OUT_MODE:   rd_word[7:0]  = output_mode_register_q;
            ADDR_CMP_A:      rd_word[15:0] = compare_reg_a_q;
            ADDR_CMP_B:      rd_word[15:0] = compare_reg_b_q;
            ADDR_COUNTER:    rd_word[15:0] = event_upcounter_q;
            ADDR_CAPTURE:    rd_word[15:0] = capture_register_q;
            ADDR_IRQ_STAT:   rd_word[2:0]  = irq_stat_q;
            ADDR_IRQ_MASK:   rd_word[2:0]  = irq_mask_q;
            ADDR_PIN_STAT:   rd_word[4:0]  = {ci_s2_q, lvl_b, lvl_a, out_b, out_a};
            default:         rd_known      = 1'b0;
        endcase
    end

    // read channel, one outstanding read
    assign s_axi_arready = ~rvalid_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            rvalid_q <= 1'b0;
            rdata_q  <= 32'h0000_0000;
            rresp_q  <= RESP_OKAY;
        end else if (s_axi_arvalid && !rvalid_q) begin
            rvalid_q <= 1'b1;
            rdata_q  <= rd_word;
            rresp_q  <= rd_known ? RESP_OKAY : RESP_DECERR;
        end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
        end
    end

    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rdata  = rdata_q;
    assign s_axi_rresp  = rresp_q;
endmodule

/* dv/ecc_top_sva.sv */
`timescale 1ns/1ps
module ecc_top_sva
    import ecc_pkg::*;
(
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // write channels
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // read channels
    input wire logic [7:0]  s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // pins
    input wire logic        hw_stop,
    input wire logic        counter_output_a,
    input wire logic        counter_output_b
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // both write channels taken
    sequence s_wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    // one busy cycle, then the answer
    sequence s_wr_answer;
        !s_axi_awready && !s_axi_wready && !s_axi_bvalid ##1 s_axi_bvalid && s_axi_awready;
    endsequence
    a_write_walk: assert property (s_wr_taken |=> s_wr_answer)
        else $error("write answer late");
    a_write_decerr: assert property (s_wr_taken ##0 s_axi_awaddr > 8'h20
        |-> ##2 s_axi_bresp == RESP_DECERR) else $error("unmapped write not refused");
    a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp)) else $error("write answer dropped");
    a_read_resp: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid) else $error("read answer late");
    a_read_decerr: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr > 8'h20
        |=> s_axi_rresp == RESP_DECERR && s_axi_rdata == 32'h0) else $error("bad unmapped read");
    a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata)) else $error("read answer dropped");
    a_arready_low: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while busy");
    // stop: pins hold
    a_stop_quiet: assert property (hw_stop [*2]
        |=> $stable(counter_output_a) && $stable(counter_output_b)) else $error("pin moved in stop");
endmodule
bind ecc_top ecc_top_sva ecc_top_sva_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .hw_stop, .counter_output_a, .counter_output_b);

/* dv/ecc_pin_model.sv */
`timescale 1ns/1ps
module ecc_pin_model (
    // clock
    input  wire logic       aclk,
    // from the bench
    input  wire logic       fire,
    input  wire logic [7:0] width,
    input  wire logic       sq_lvl,
    // to the block; busy back to the bench
    output logic            count_input_pin,
    output logic            timer_square_out,
    output logic            busy
);
    logic [7:0] left_q;
    initial {left_q, count_input_pin, timer_square_out} = '0;
    // high pulse of width cycles, low between
    always @(posedge aclk) begin
        if (fire) begin
            left_q <= width;
        end else if (left_q != 8'h00) begin
            left_q <= left_q - 8'h01;
        end
        count_input_pin  <= fire || left_q > 8'h01;
        timer_square_out <= sq_lvl; // same-clock level
    end
    assign busy = fire || left_q != 8'h00;
endmodule

/* dv/tb_ecc_top.sv */
`timescale 1ns/1ps
module tb_ecc_top;
    import ecc_pkg::*;
    logic        aclk, aresetn, hw_stop, awvalid, wvalid, bready, arvalid, rready, fire, sq_lvl;
    logic [7:0]  awaddr, araddr, width;
    logic [31:0] wdata, v;
    logic [3:0]  wstrb;
    wire logic   awready, wready, bvalid, arready, rvalid, irq, out_a, out_b, cin, sq, busy;
    wire logic [1:0]  bresp, rresp;
    wire logic [31:0] rdata;
    int          error_cnt, n_checks, seed;
    logic [33:0] exp_q[$];

    ecc_top ecc_top_inst (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .count_input_pin(cin), .timer_square_out(sq), .hw_stop(hw_stop),
        .counter_output_a(out_a), .counter_output_b(out_b), .irq(irq));
    ecc_pin_model ecc_pin_model_inst (.aclk(aclk), .fire(fire), .width(width), .sq_lvl(sq_lvl),
        .count_input_pin(cin), .timer_square_out(sq), .busy(busy));

    initial begin
        aclk = 1'b0;
        forever #20 aclk = ~aclk;
    end

    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic tmo();
        error_cnt++;
        $display("mismatch at %0t: wait ran out", $time);
        wrap_up();
    endtask

    task automatic chk(input logic [33:0] e, input logic [33:0] got);
        n_checks++;
        if (got !== e) begin
            error_cnt++;
            $display("mismatch at %0t: got %h expected %h", $time, got, e);
        end
    endtask

    // write; bready comes late to test the hold
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        int   n;
        logic done;
        @(posedge aclk);
        awaddr  <= a;
        wdata   <= d;
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            done = bvalid && bready;
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (n == 2) bready <= 1'b1;
            n++;
        end while (!done && n < 60);
        bready <= 1'b0;
        if (!done) tmo();
    endtask

    // read; the watcher checks it
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        int   n;
        logic done;
        @(posedge aclk);
        exp_q.push_back(e);
        araddr  <= a;
        arvalid <= 1'b1;
        n = 0;
        do begin
            @(posedge aclk);
            done = rvalid && rready;
            if (arready) arvalid <= 1'b0;
            if (n == 1) rready <= 1'b1;
            n++;
        end while (!done && n < 60);
        rready <= 1'b0;
        if (!done) tmo();
    endtask

    always @(posedge aclk) begin
        if (rvalid && rready) chk(exp_q.pop_front(), {rresp, rdata});
    end

    // one count-input pulse, then sync slack
    task automatic pulse(input logic [7:0] w);
        int n;
        @(posedge aclk);
        fire  <= 1'b1;
        width <= w;
        @(posedge aclk);
        fire <= 1'b0;
        for (n = 0; busy && n < 300; n++) @(posedge aclk);
        if (n >= 300) tmo();
        repeat (6) @(posedge aclk);
    endtask

    // wait for lvl on pin a, then time it
    task automatic span(input logic lvl, input int e);
        int n;
        int len;
        for (n = 0; out_a !== lvl && n < 200; n++) @(posedge aclk);
        for (len = 0; out_a === lvl && len < 200; len++) @(posedge aclk);
        if (n >= 200) tmo();
        chk(34'(e), 34'(len));
    endtask

    initial begin
        {aresetn, hw_stop, awvalid, wvalid, bready, arvalid, rready, fire, sq_lvl} = '0;
        {awaddr, araddr, width, wdata} = '0;
        wstrb = 4'hF;
        seed  = 32'h9924023d;
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        for (int i = 0; i < 24; i += 4) rd(8'(i), 34'h0);
        rd(8'h40, {RESP_DECERR, 32'h0});
        wr(8'h44, 32'hFF);
        $display("test reset done");
        wr(ADDR_CMP_A, 32'h0100);
        wr(ADDR_CMP_B, 32'h0200);
        wr(ADDR_IRQ_MASK, 32'h7);
        wr(ADDR_IRQ_STAT, 32'h7);
        wr(ADDR_EVENT_MODE, 32'h09);
        wr(ADDR_COUNTER, 32'h0);
        pulse(8'd120);
        rd(ADDR_CAPTURE, {RESP_OKAY, 32'd10});
        rd(ADDR_COUNTER, {RESP_OKAY, 32'h0});
        rd(ADDR_IRQ_STAT, {RESP_OKAY, 32'h4});
        chk(34'(irq), 34'h1);
        wr(ADDR_IRQ_MASK, 32'h3);
        chk(34'(irq), 34'h0);
        wr(ADDR_IRQ_STAT, 32'h4);
        wr(ADDR_IRQ_MASK, 32'h7);
        chk(34'(irq), 34'h0);
        $display("test pulse width done");
        wr(ADDR_EVENT_MODE, 32'h00);
        wr(ADDR_CMP_A, 32'h3);
        wr(ADDR_CMP_B, 32'h7);
        wr(ADDR_COUNTER, 32'h0);
        wr(ADDR_OUT_MODE, 32'h0A);
        rd(ADDR_OUT_MODE, {RESP_OKAY, 32'h02});
        wr(ADDR_EVENT_MODE, 32'h3E);
        span(1'b1, 48);
        span(1'b0, 36);
        wr(ADDR_EVENT_MODE, 32'h00);
        wr(ADDR_OUT_MODE, 32'h80);
        wr(ADDR_OUT_MODE, 32'h10);
        chk(34'(out_b), 34'h1);
        rd(ADDR_OUT_MODE, {RESP_OKAY, 32'h00});
        $display("test square wave done");
        wr(ADDR_EVENT_MODE, 32'h3E);
        hw_stop <= 1'b1;
        repeat (3) @(posedge aclk);
        hw_stop <= 1'b0;
        rd(ADDR_EVENT_MODE, {RESP_OKAY, 32'h0});
        rd(ADDR_OUT_MODE, {RESP_OKAY, 32'h0});
        $display("test stop done");
        wr(ADDR_EVENT_MODE, 32'h03);
        wr(ADDR_COUNTER, 32'h0);
        sq_lvl <= 1'b1;
        repeat (3) pulse(8'd4);
        sq_lvl <= 1'b0;
        repeat (4) @(posedge aclk);
        rd(ADDR_CAPTURE, {RESP_OKAY, 32'd3});
        rd(ADDR_COUNTER, {RESP_OKAY, 32'd3});
        $display("test square capture done");
        wr(ADDR_EVENT_MODE, 32'h00);
        repeat (4) begin
            v = $random(seed);
            wr(ADDR_CMP_B, v);
            rd(ADDR_CMP_B, {RESP_OKAY, 16'h0, v[15:0]});
        end
        $display("test random compare done");
        wrap_up();
    end
endmodule
